// ==== rtl/blmfm_pkg.sv ====
// package for the bias, leak and motor fault monitor
// assumes a single 125 MHz clock; holds thresholds, times and codes
package blmfm_pkg;

  // ------------------------------------------------------------
  // clock and times
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 125000000; // system clock rate
  localparam int unsigned BIAS_HOLD_MS    = 500;       // bias hold time, ms
  localparam int unsigned LEAK_DELAY_MS   = 1000;      // corona settle, ms
  localparam int unsigned LEAK_GAP_MS     = 1000;      // leak sample spacing, ms
  localparam int unsigned MOTOR_START_MS  = 1000;      // motor start window, ms
  localparam int unsigned MOTOR_RUN_MS    = 2000;      // motor run window, ms
  // cycle counts derived from the times (exact at this rate)
  localparam int unsigned BIAS_HOLD_CYC   = BIAS_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned LEAK_DELAY_CYC  = LEAK_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned LEAK_GAP_CYC    = LEAK_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned MOTOR_START_CYC = MOTOR_START_MS * (CLK_HZ / 1000);
  localparam int unsigned MOTOR_RUN_CYC   = MOTOR_RUN_MS * (CLK_HZ / 1000);

  // ------------------------------------------------------------
  // analogue thresholds
  // ------------------------------------------------------------
  localparam int unsigned ADC_W           = 10;        // feedback adc width
  localparam int unsigned ADC_FULL_MV     = 5000;      // adc full scale, mV
  localparam int unsigned FB_LIMIT_MV     = 4800;      // feedback leak level, mV
  localparam logic [9:0]  FB_LIMIT        = 10'(FB_LIMIT_MV * 1023 / ADC_FULL_MV);
  localparam int unsigned PWM_W           = 8;         // duty word width
  localparam logic [7:0]  PWM_LIMIT       = 8'h80;     // 50 percent of 256

  // ------------------------------------------------------------
  // fault codes, one bit each in the fault vector
  // ------------------------------------------------------------
  localparam int unsigned NUM_FAULT       = 4;
  localparam int unsigned BELT_BIAS_BIT   = 0;
  localparam int unsigned CORONA_LEAK_BIT = 1;
  localparam int unsigned DRUM_MOTOR_BIT  = 2;
  localparam int unsigned PAPER_BIAS_BIT  = 3;
  localparam logic [9:0]  BELT_BIAS_FAULT_CODE   = 10'h190;
  localparam logic [9:0]  CORONA_LEAK_FAULT_CODE = 10'h1A6;
  localparam logic [9:0]  DRUM_MOTOR_FAULT_CODE  = 10'h1B8;
  localparam logic [9:0]  PAPER_BIAS_FAULT_CODE  = 10'h1C2;
  localparam logic [9:0]  NO_FAULT_CODE          = 10'h000;

  // leak sampler states
  typedef enum logic [1:0] {
    BLMFM_LK_IDLE   = 2'b00, // corona off
    BLMFM_LK_SETTLE = 2'b01, // waiting after switch on
    BLMFM_LK_FIRST  = 2'b10, // waiting for first sample
    BLMFM_LK_SECOND = 2'b11  // first sample saw a leak
  } blmfm_leak_type;

endpackage

// ==== rtl/blmfm_bias_mon.sv ====
// one bias supply monitor: feedback or duty too high for a hold time
// assumes feedback and duty are already synchronised to clk
`timescale 1ns/1ps
module blmfm_bias_mon #(
  parameter int unsigned HOLD_CYC = blmfm_pkg::BIAS_HOLD_CYC
) (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            ce,
  input  wire logic                            active,
  input  wire logic [blmfm_pkg::ADC_W-1:0]    feedback,
  input  wire logic [blmfm_pkg::PWM_W-1:0]    duty,
  output logic                                 fault
);

  // ------------------------------------------------------------
  // qualifier
  // ------------------------------------------------------------
  logic [31:0] cnt_q;   // cycles the condition has held
  logic        cond;    // leak indication this cycle

  // either limit counts as a leak
  assign cond = (feedback >= blmfm_pkg::FB_LIMIT) || (duty >= blmfm_pkg::PWM_LIMIT);

  // count only while active; restart on any break
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= 32'h0;
    else if (ce)
    begin
      if (!(active && cond))
        cnt_q <= 32'h0;
      else if (cnt_q < HOLD_CYC)
        cnt_q <= cnt_q + 32'h1;
    end
  end

  // latched until reset
  always_ff @(posedge clk)
  begin
    if (rst)
      fault <= 1'b0;
    else if (ce && active && cond && cnt_q == HOLD_CYC - 1)
      fault <= 1'b1;
  end

endmodule // blmfm_bias_mon

// ==== rtl/blmfm_top.sv ====
// top of the bias, leak and motor fault monitor
// assumes supply feedback arrives as asynchronous pins; triggers come
// from logic on the same clock; faults stay until reset
//
// Summary of operation
// - belt bias checked only while bias on
// - belt feedback or duty high 500 ms
// - leak sampling starts 1 s after on
// - two leak samples 1 s apart
// - leak fault when both samples leak
// - motor not ready 1 s after trigger
// - motor bad 2 s while trigger on
// - paper bias checked only while printing
// - paper feedback or duty high 500 ms
`timescale 1ns/1ps
module blmfm_top #(
  parameter int unsigned BIAS_HOLD_CYC   = blmfm_pkg::BIAS_HOLD_CYC,
  parameter int unsigned LEAK_DELAY_CYC  = blmfm_pkg::LEAK_DELAY_CYC,
  parameter int unsigned LEAK_GAP_CYC    = blmfm_pkg::LEAK_GAP_CYC,
  parameter int unsigned MOTOR_START_CYC = blmfm_pkg::MOTOR_START_CYC,
  parameter int unsigned MOTOR_RUN_CYC   = blmfm_pkg::MOTOR_RUN_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic                          printing,
  input  wire logic                          self_check,
  input  wire logic                          belt_bias_on,
  input  wire logic [blmfm_pkg::ADC_W-1:0]  belt_fb,
  input  wire logic [blmfm_pkg::PWM_W-1:0]  belt_duty,
  input  wire logic                          cleaning_corona_on,
  input  wire logic                          corona_leak,
  input  wire logic                          drum_trigger,
  input  wire logic                          drum_motor_ok,
  input  wire logic                          paper_bias_on,
  input  wire logic [blmfm_pkg::ADC_W-1:0]  paper_fb,
  input  wire logic [blmfm_pkg::PWM_W-1:0]  paper_duty,
  output logic [blmfm_pkg::NUM_FAULT-1:0]   fault_q,
  output logic                               fault_any_q,
  output logic [9:0]                         fault_code_q
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [blmfm_pkg::ADC_W-1:0] belt_fb_m_q, belt_fb_q;   // belt feedback
  logic [blmfm_pkg::ADC_W-1:0] paper_fb_m_q, paper_fb_q; // paper feedback
  logic [1:0]                  leak_s_q;                 // corona leak pin
  logic [1:0]                  mok_s_q;                  // motor ok pin

  // two stages per pin; a slow analogue word tolerates bit skew
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      belt_fb_m_q  <= '0;
      belt_fb_q    <= '0;
      paper_fb_m_q <= '0;
      paper_fb_q   <= '0;
      leak_s_q     <= 2'h0;
      mok_s_q      <= 2'h0;
    end
    else if (ce)
    begin
      belt_fb_m_q  <= belt_fb;
      belt_fb_q    <= belt_fb_m_q;
      paper_fb_m_q <= paper_fb;
      paper_fb_q   <= paper_fb_m_q;
      leak_s_q     <= {leak_s_q[0], corona_leak};
      mok_s_q      <= {mok_s_q[0], drum_motor_ok};
    end
  end

  logic leak_now;  // synchronised leak level
  logic mok_now;   // synchronised motor ok level
  assign leak_now = leak_s_q[1];
  assign mok_now  = mok_s_q[1];

  // ------------------------------------------------------------
  // bias monitors
  // ------------------------------------------------------------
  logic belt_act;   // belt bias under watch
  logic paper_act;  // paper bias under watch
  logic belt_flt;   // belt monitor result
  logic paper_flt;  // paper monitor result

  assign belt_act  = belt_bias_on && (printing || self_check);
  assign paper_act = paper_bias_on && printing;

  blmfm_bias_mon #(.HOLD_CYC(BIAS_HOLD_CYC)) u_belt (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .active   (belt_act),
    .feedback (belt_fb_q),
    .duty     (belt_duty),
    .fault    (belt_flt)
  );

  blmfm_bias_mon #(.HOLD_CYC(BIAS_HOLD_CYC)) u_paper (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .active   (paper_act),
    .feedback (paper_fb_q),
    .duty     (paper_duty),
    .fault    (paper_flt)
  );

  // ------------------------------------------------------------
  // corona leak sampler
  // ------------------------------------------------------------
  blmfm_pkg::blmfm_leak_type lk_q;  // sampler state
  logic [31:0]               lk_cnt_q; // time in state
  logic                      leak_flt; // leak event this cycle

  // sample at end of each wait; a clean sample restarts the pair
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lk_q     <= blmfm_pkg::BLMFM_LK_IDLE;
      lk_cnt_q <= 32'h0;
    end
    else if (ce)
    begin
      if (!cleaning_corona_on)
      begin
        lk_q     <= blmfm_pkg::BLMFM_LK_IDLE;
        lk_cnt_q <= 32'h0;
      end
      else
      begin
        case (lk_q)
          blmfm_pkg::BLMFM_LK_IDLE:
          begin
            lk_q     <= blmfm_pkg::BLMFM_LK_SETTLE;
            lk_cnt_q <= 32'h1;
          end
          blmfm_pkg::BLMFM_LK_SETTLE:
          begin
            if (lk_cnt_q >= LEAK_DELAY_CYC - 1)
            begin
              lk_q     <= leak_now ? blmfm_pkg::BLMFM_LK_SECOND
                                   : blmfm_pkg::BLMFM_LK_FIRST;
              lk_cnt_q <= 32'h0;
            end
            else
              lk_cnt_q <= lk_cnt_q + 32'h1;
          end
          default:
          begin
            if (lk_cnt_q >= LEAK_GAP_CYC - 1)
            begin
              lk_q     <= leak_now ? blmfm_pkg::BLMFM_LK_SECOND
                                   : blmfm_pkg::BLMFM_LK_FIRST;
              lk_cnt_q <= 32'h0;
            end
            else
              lk_cnt_q <= lk_cnt_q + 32'h1;
          end
        endcase
      end
    end
  end

  assign leak_flt = cleaning_corona_on && (lk_q == blmfm_pkg::BLMFM_LK_SECOND)
                    && (lk_cnt_q >= LEAK_GAP_CYC - 1) && leak_now;

  // ------------------------------------------------------------
  // drum motor supervisor
  // ------------------------------------------------------------
  logic [31:0] st_cnt_q;  // cycles since trigger went on
  logic [31:0] bad_cnt_q; // cycles feedback out of range
  logic        motor_flt; // motor event this cycle

  // start window timer, saturating just past the limit
  always_ff @(posedge clk)
  begin
    if (rst)
      st_cnt_q <= 32'h0;
    else if (ce)
    begin
      if (!drum_trigger)
        st_cnt_q <= 32'h0;
      else if (st_cnt_q < MOTOR_START_CYC)
        st_cnt_q <= st_cnt_q + 32'h1;
    end
  end

  // running out-of-range timer
  always_ff @(posedge clk)
  begin
    if (rst)
      bad_cnt_q <= 32'h0;
    else if (ce)
    begin
      if (!drum_trigger || mok_now)
        bad_cnt_q <= 32'h0;
      else if (bad_cnt_q < MOTOR_RUN_CYC)
        bad_cnt_q <= bad_cnt_q + 32'h1;
    end
  end

  assign motor_flt = drum_trigger && !mok_now &&
                     ((st_cnt_q == MOTOR_START_CYC - 1) ||
                      (bad_cnt_q == MOTOR_RUN_CYC - 1));

  // ------------------------------------------------------------
  // fault latch and reporting
  // ------------------------------------------------------------
  logic [blmfm_pkg::NUM_FAULT-1:0] ev; // fault events this cycle
  assign ev[blmfm_pkg::BELT_BIAS_BIT]   = belt_flt;
  assign ev[blmfm_pkg::CORONA_LEAK_BIT] = ce && leak_flt;
  assign ev[blmfm_pkg::DRUM_MOTOR_BIT]  = ce && motor_flt;
  assign ev[blmfm_pkg::PAPER_BIAS_BIT]  = paper_flt;

  // sticky until reset; frozen with ce low like the rest
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fault_q     <= '0;
      fault_any_q <= 1'b0;
    end
    else if (ce)
    begin
      fault_q     <= fault_q | ev;
      fault_any_q <= |(fault_q | ev);
    end
  end

  // first fault code wins and is kept
  always_ff @(posedge clk)
  begin
    if (rst)
      fault_code_q <= blmfm_pkg::NO_FAULT_CODE;
    else if (ce && fault_code_q == blmfm_pkg::NO_FAULT_CODE)
    begin
      if (ev[blmfm_pkg::BELT_BIAS_BIT])
        fault_code_q <= blmfm_pkg::BELT_BIAS_FAULT_CODE;
      else if (ev[blmfm_pkg::CORONA_LEAK_BIT])
        fault_code_q <= blmfm_pkg::CORONA_LEAK_FAULT_CODE;
      else if (ev[blmfm_pkg::DRUM_MOTOR_BIT])
        fault_code_q <= blmfm_pkg::DRUM_MOTOR_FAULT_CODE;
      else if (ev[blmfm_pkg::PAPER_BIAS_BIT])
        fault_code_q <= blmfm_pkg::PAPER_BIAS_FAULT_CODE;
    end
  end

endmodule // blmfm_top

// ==== bench/blmfm_chk_sva.sv ====
// checker for the fault monitor top: hold times, latching and codes
// assumes binding to blmfm_top with the same count parameters
`timescale 1ns/1ps
module blmfm_chk #(
  parameter int unsigned BIAS_HOLD_CYC   = 20,
  parameter int unsigned LEAK_DELAY_CYC  = 30,
  parameter int unsigned LEAK_GAP_CYC    = 30,
  parameter int unsigned MOTOR_START_CYC = 25,
  parameter int unsigned MOTOR_RUN_CYC   = 50
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       printing,
  input wire logic       self_check,
  input wire logic       belt_bias_on,
  input wire logic [9:0] belt_fb,
  input wire logic [7:0] belt_duty,
  input wire logic       cleaning_corona_on,
  input wire logic       corona_leak,
  input wire logic       drum_trigger,
  input wire logic       drum_motor_ok,
  input wire logic       paper_bias_on,
  input wire logic [9:0] paper_fb,
  input wire logic [7:0] paper_duty,
  input wire logic [3:0] fault_q,
  input wire logic       fault_any_q,
  input wire logic [9:0] fault_code_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic belt_act = belt_bias_on && (printing || self_check); // belt monitor live
  wire logic belt_hi  = belt_act && belt_duty >= blmfm_pkg::PWM_LIMIT; // duty leak
  wire logic drum_bad = drum_trigger && !drum_motor_ok; // raw, before sync
  logic [15:0] ba_q, bc_q, pa_q, co_q, tr_q, bd_q; // consecutive-cycle counts
  // counts freeze with ce low, as the design's qualifiers do
  always_ff @(posedge clk)
  begin
    if (rst)
      {ba_q, bc_q, pa_q, co_q, tr_q, bd_q} <= '0;
    else if (ce)
    begin
      ba_q <= belt_act ? ba_q + 16'h1 : 16'h0;
      bc_q <= belt_hi ? bc_q + 16'h1 : 16'h0;
      pa_q <= (paper_bias_on && printing) ? pa_q + 16'h1 : 16'h0;
      co_q <= cleaning_corona_on ? co_q + 16'h1 : 16'h0;
      tr_q <= drum_trigger ? tr_q + 16'h1 : 16'h0;
      bd_q <= drum_bad ? bd_q + 16'h1 : 16'h0;
    end
  end
  // lowest set bit wins, matching same-cycle priority
  function automatic logic [9:0] code_of(input logic [3:0] f);
    if (f[0]) return blmfm_pkg::BELT_BIAS_FAULT_CODE;
    if (f[1]) return blmfm_pkg::CORONA_LEAK_FAULT_CODE;
    if (f[2]) return blmfm_pkg::DRUM_MOTOR_FAULT_CODE;
    return blmfm_pkg::PAPER_BIAS_FAULT_CODE;
  endfunction
  a_reset_clears: assert property (disable iff (1'b0) rst |=>
    fault_q == 4'h0 && !fault_any_q && fault_code_q == 10'h000) else $error("not cleared");
  a_faults_sticky: assert property (1'b1 |=>
    (fault_q & $past(fault_q)) == $past(fault_q)) else $error("fault dropped");
  a_code_holds: assert property (fault_any_q |=> $stable(fault_code_q))
    else $error("code changed");
  a_any_matches: assert property (fault_any_q == (|fault_q)) else $error("any wrong");
  a_code_first: assert property ($rose(fault_any_q) |->
    fault_code_q == code_of(fault_q)) else $error("code wrong");
  a_belt_active_hold: assert property ($rose(fault_q[0]) |->
    $past(ba_q) >= BIAS_HOLD_CYC - 1) else $error("belt fault early");
  a_belt_duty_fires: assert property (bc_q == BIAS_HOLD_CYC + 3 |-> fault_q[0])
    else $error("belt fault missing");
  a_paper_active_hold: assert property ($rose(fault_q[3]) |->
    $past(pa_q) >= BIAS_HOLD_CYC - 1) else $error("paper fault early");
  a_leak_after_pair: assert property ($rose(fault_q[1]) |->
    $past(co_q) >= LEAK_DELAY_CYC + LEAK_GAP_CYC - 1) else $error("leak fault early");
  a_motor_start_wait: assert property ($rose(fault_q[2]) |->
    $past(tr_q) >= MOTOR_START_CYC - 2) else $error("motor fault early");
  a_motor_start_fires: assert property (bd_q == tr_q &&
    bd_q == MOTOR_START_CYC + 4 |-> fault_q[2]) else $error("start fault missing");
  a_motor_run_fires: assert property (bd_q == MOTOR_RUN_CYC + 5 |-> fault_q[2])
    else $error("run fault missing");
  c_belt: cover property ($rose(fault_q[0]));
  c_leak: cover property ($rose(fault_q[1]));
  c_motor: cover property ($rose(fault_q[2]));
  c_paper: cover property ($rose(fault_q[3]));
endmodule // blmfm_chk

bind blmfm_top blmfm_chk #(.BIAS_HOLD_CYC(BIAS_HOLD_CYC), .LEAK_DELAY_CYC(LEAK_DELAY_CYC),
  .LEAK_GAP_CYC(LEAK_GAP_CYC), .MOTOR_START_CYC(MOTOR_START_CYC),
  .MOTOR_RUN_CYC(MOTOR_RUN_CYC)) blmfm_chk_inst (.clk, .rst, .ce, .printing, .self_check,
  .belt_bias_on, .belt_fb, .belt_duty, .cleaning_corona_on, .corona_leak, .drum_trigger,
  .drum_motor_ok, .paper_bias_on, .paper_fb, .paper_duty, .fault_q, .fault_any_q,
  .fault_code_q);

// ==== bench/blmfm_hv_model.sv ====
// model of the high voltage supply board and the drum motor driver
// assumes the bench sets feedback levels, leak and motor health
`timescale 1ns/1ps
module blmfm_hv_model (
  input  wire logic       clk,
  input  wire logic       belt_bias_on,
  input  wire logic       paper_bias_on,
  input  wire logic       cleaning_corona_on,
  input  wire logic       drum_trigger,
  input  wire logic [9:0] belt_lvl,
  input  wire logic [9:0] paper_lvl,
  input  wire logic       leak_req,
  input  wire logic       motor_good,
  output logic      [9:0] belt_fb,
  output logic      [9:0] paper_fb,
  output logic            corona_leak,
  output logic            drum_motor_ok
);
  logic [3:0] spin_q; // cycles since trigger, saturating
  // the motor needs a few cycles to come into range
  always_ff @(posedge clk)
  begin
    if (!drum_trigger)
      spin_q <= 4'h0;
    else if (spin_q != 4'hF)
      spin_q <= spin_q + 4'h1;
  end
  // a supply that is off reads ground, not its last level
  assign belt_fb       = belt_bias_on ? belt_lvl : 10'h000;
  assign paper_fb      = paper_bias_on ? paper_lvl : 10'h000;
  assign corona_leak   = cleaning_corona_on && leak_req; // no leak current when off
  assign drum_motor_ok = drum_trigger && motor_good && (spin_q > 4'h4);
endmodule // blmfm_hv_model

// ==== bench/testbench.sv ====
// self-checking bench for the fault monitor top beside a supply model
// assumes shortened counts, ce held high and a 125 MHz clock
`timescale 1ns/1ps
module testbench;
  localparam int HOLD = 20, DLY = 30, GAP = 30, MST = 25, MRUN = 50; // shortened counts
  logic       clk, rst, ce, printing, self_check, belt_bias_on, paper_bias_on;
  logic       cleaning_corona_on, corona_leak, drum_trigger, drum_motor_ok;
  logic       leak_req, motor_good, fault_any_q;
  logic [9:0] belt_fb, paper_fb, belt_lvl, paper_lvl, fault_code_q;
  logic [7:0] belt_duty, paper_duty;
  logic [3:0] fault_q;
  int         n_fail, n_compared;
  blmfm_top #(.BIAS_HOLD_CYC(HOLD), .LEAK_DELAY_CYC(DLY), .LEAK_GAP_CYC(GAP),
    .MOTOR_START_CYC(MST), .MOTOR_RUN_CYC(MRUN)) blmfm_top_inst (.clk, .rst, .ce,
    .printing, .self_check, .belt_bias_on, .belt_fb, .belt_duty, .cleaning_corona_on,
    .corona_leak, .drum_trigger, .drum_motor_ok, .paper_bias_on, .paper_fb, .paper_duty,
    .fault_q, .fault_any_q, .fault_code_q);
  blmfm_hv_model blmfm_hv_model_inst (.clk, .belt_bias_on, .paper_bias_on,
    .cleaning_corona_on, .drum_trigger, .belt_lvl, .paper_lvl, .leak_req, .motor_good,
    .belt_fb, .paper_fb, .corona_leak, .drum_motor_ok);
  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string nm);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // inputs always move 1 ns after the rising edge
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // everything off, reset for 2 cycles; a mid-run reset for each scenario
  task automatic idle();
    {printing, self_check, belt_bias_on, paper_bias_on, cleaning_corona_on} = '0;
    {drum_trigger, leak_req, belt_duty, paper_duty, belt_lvl, paper_lvl} = '0;
    motor_good = 1'b1;
    rst = 1'b1;
    go(2);
    rst = 1'b0;
    chk({fault_any_q, fault_q, 5'h00}, 10'h000, "rst_out");
    chk(fault_code_q, 10'h000, "rst_code");
  endtask
  // the fault bit must stay low lo cycles, then rise before hi
  task automatic win(input int b, input int lo, input int hi, input string nm);
    int t;
    t = 0;
    while (fault_q[b] !== 1'b1 && t < hi)
    begin
      go(1);
      t++;
    end
    chk(10'(t >= lo && t < hi), 10'h001, nm);
  endtask
  task automatic t_belt();
    idle();
    belt_bias_on = 1'b1;
    belt_duty = 8'h80; // on, but neither printing nor self check
    go(HOLD + 10);
    chk(10'(fault_q), 10'h000, "belt_idle");
    printing = 1'b1;
    belt_duty = 8'h7F; // one step under each limit
    belt_lvl = 10'h3D5;
    go(HOLD + 10);
    chk(10'(fault_q), 10'h000, "belt_under");
    belt_duty = 8'h80;
    go(HOLD - 5);
    belt_duty = 8'h00; // one-cycle break restarts the hold
    go(1);
    belt_duty = 8'h80;
    go(HOLD - 5);
    belt_duty = 8'h00;
    chk(10'(fault_q), 10'h000, "belt_break");
    go(2);
    printing = 1'b0;
    self_check = 1'b1;
    belt_lvl = 10'h3D6; // feedback exactly at the limit
    win(0, HOLD - 2, HOLD + 8, "belt_fb");
    chk(fault_code_q, blmfm_pkg::BELT_BIAS_FAULT_CODE, "belt_code");
    belt_bias_on = 1'b0;
    go(5);
    chk({fault_any_q, fault_q[0]}, 10'h003, "belt_latch");
  endtask
  task automatic t_paper();
    idle();
    paper_bias_on = 1'b1;
    self_check = 1'b1; // self check alone does not arm it
    paper_duty = 8'h80;
    go(HOLD + 10);
    chk(10'(fault_q), 10'h000, "paper_self");
    printing = 1'b1;
    win(3, HOLD - 2, HOLD + 6, "paper_duty");
    belt_bias_on = 1'b1;
    belt_lvl = 10'h3FF;
    belt_duty = 8'h80; // duty path of the belt monitor too
    go(HOLD + 8);
    chk(10'(fault_q), 10'h009, "two_faults");
    chk(fault_code_q, blmfm_pkg::PAPER_BIAS_FAULT_CODE, "first_code");
    idle();
    paper_bias_on = 1'b1;
    printing = 1'b1;
    paper_lvl = 10'h3D6; // feedback at the limit, duty idle
    win(3, HOLD + 1, HOLD + 6, "paper_fb");
  endtask
  task automatic t_leak();
    idle();
    cleaning_corona_on = 1'b1;
    leak_req = 1'b1; // leak only while the corona settles
    go(20);
    leak_req = 1'b0;
    go(DLY + 2 * GAP + 10);
    chk(10'(fault_q), 10'h000, "leak_settle");
    idle();
    cleaning_corona_on = 1'b1;
    go(DLY + GAP / 2); // first sample low, leak starts between samples
    leak_req = 1'b1;
    win(1, GAP, 2 * GAP, "leak_two");
    chk(fault_code_q, blmfm_pkg::CORONA_LEAK_FAULT_CODE, "leak_code");
    idle();
    cleaning_corona_on = 1'b1;
    leak_req = 1'b1; // leak from switch on: fault at the second sample
    win(1, DLY + GAP - 1, DLY + GAP + 2, "leak_first");
  endtask
  task automatic t_motor();
    idle();
    motor_good = 1'b0;
    go(MRUN + 10); // bad motor but no trigger
    chk(10'(fault_q), 10'h000, "motor_off");
    drum_trigger = 1'b1;
    win(2, MST - 3, MST + 8, "motor_start");
    chk(fault_code_q, blmfm_pkg::DRUM_MOTOR_FAULT_CODE, "motor_code");
    go(8); // run on past the start limit with the fault held
    idle();
    drum_trigger = 1'b1;
    go(MRUN + 20);
    chk(10'(fault_q), 10'h000, "motor_good");
    motor_good = 1'b0; // drops out while running
    win(2, MRUN - 2, MRUN + 8, "motor_run");
    go(8);
    chk(fault_code_q, blmfm_pkg::DRUM_MOTOR_FAULT_CODE, "motor_run_code");
  endtask
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence; ce is the one tied input
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    ce = 1'b1;
    idle();
    t_belt();
    t_paper();
    t_leak();
    t_motor();
    wrap_up();
  end
  // watchdog, several times the expected run
  initial
  begin
    #40000;
    n_fail++;
    wrap_up();
  end
endmodule // testbench
